// *** rtl/svrt_pkg.sv ***
// Constants and types shared by the shared video RAM timing block.
//
// Functional notes
// RULE1: Phase clock is main clock divided by four.
// RULE2: Video generator owns RAM while phase low.
// RULE3: Address strobe latches multiplexed address, phase low.
// RULE4: Processor holds bus valid through phase high.
// RULE5: RAM write strobe is qualified by gate.
// RULE6: Sync falling edge allowed only inside gate.
// RULE7: Video data captured at end of phase low.
// RULE8: Owner select steers shared RAM address lines.
// RULE9: Shared address bit eleven picks RAM chip.
// RULE10: Both RAM output enables permanently active.
// RULE11: Write strobe high except processor RAM write.
// RULE12: Two 2K byte RAMs, 4K total shared.
// RULE13: Top two bits split map into 16K segments.
// RULE14: Address bit twelve blocks RAM write aliasing.
// RULE15: Gate opens after settle, closes before fall.
package svrt_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam longint CLK_HZ = 40000000;
	localparam longint CLK_PERIOD_NS = 25;
	localparam longint OSC_HZ = 3579545;
	localparam int PHASE_DIV = 4;
	localparam int NCO_WIDTH = 24;
	localparam logic [NCO_WIDTH-1:0] NCO_INC =
		NCO_WIDTH'((OSC_HZ * (64'd1 << NCO_WIDTH)) / CLK_HZ);
	localparam logic [NCO_WIDTH-1:0] NCO_RESET = 24'h000000;

	// Shortest oscillator period in whole system clock cycles.
	localparam logic [3:0] OSC_MIN_CYC = 4'(CLK_HZ / OSC_HZ);

	localparam longint WIN_SETUP_NS = 50;
	localparam longint WIN_GUARD_NS = 75;
	localparam logic [3:0] WIN_SETUP_CYC =
		4'((WIN_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WIN_GUARD_CYC =
		4'((WIN_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WIN_END_SUB = OSC_MIN_CYC - WIN_GUARD_CYC;

	////////////////////////////////////////////////////////////////////////
	localparam int ADDR_WIDTH = 16;
	localparam int SHARED_WIDTH = 12;
	localparam int CHIP_WIDTH = 11;
	localparam int DATA_WIDTH = 8;
	localparam int CHIP_COUNT = 2;
	localparam int SEG_MSB = 15;
	localparam int SEG_LSB = 14;
	localparam int ALIAS_BIT = 12;
	localparam int CHIP_SEL_BIT = 11;

	localparam logic [1:0] SEG_INTERNAL = 2'h0;
	localparam logic [1:0] SEG_RAM = 2'h1;
	localparam logic [1:0] SEG_IO = 2'h2;
	localparam logic [1:0] SEG_ROM = 2'h3;

	// Quarters of the phase clock; the upper bit is the phase level.
	localparam logic [1:0] QTR_LOW_A = 2'h0;
	localparam logic [1:0] QTR_LOW_B = 2'h1;
	localparam logic [1:0] QTR_HIGH_A = 2'h2;
	localparam logic [1:0] QTR_HIGH_B = 2'h3;

	typedef enum logic [1:0]
	{
		SYNC_HIGH = 2'b00,
		SYNC_HELD = 2'b01,
		SYNC_LOW = 2'b10
	} svrt_sync_type;

endpackage

// *** rtl/svrt_ram.sv ***
// Shared static RAM storage: two byte-wide chips selected by one address bit.
`timescale 1ns/10ps
module svrt_ram #(
	parameter int CHIPS = svrt_pkg::CHIP_COUNT,
	parameter int CWIDTH = svrt_pkg::CHIP_WIDTH,
	parameter int DWIDTH = svrt_pkg::DATA_WIDTH
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [CWIDTH:0] addr,
	input wire logic [DWIDTH-1:0] wdata,
	input wire logic we_n,
	output logic [DWIDTH-1:0] rdata
);
	import svrt_pkg::*;

	typedef struct packed
	{
		logic [CHIPS-1:0][(1<<CWIDTH)-1:0][DWIDTH-1:0] mem;
	} svrt_ram_state_type;

	svrt_ram_state_type state_q;
	svrt_ram_state_type state_d;
	logic chip;
	logic [CWIDTH-1:0] index;

	////////////////////////////////////////////////////////////////////////
	assign chip = addr[CWIDTH]; // see RULE9
	assign index = addr[CWIDTH-1:0];

	// Output enables are always active, so the selected chip always drives.
	assign rdata = state_q.mem[chip][index]; // see RULE10

	always_comb
	begin
		state_d = state_q;
		if (!we_n)
		begin
			state_d.mem[chip][index] = wdata; // see RULE12
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= '0;
		end
		else
		begin
			state_q <= state_d;
		end
	end

endmodule

// *** rtl/svrt_top.sv ***
// Phase clock, safe-access gate and shared RAM arbitration for processor/video.
`timescale 1ns/10ps
module svrt_top
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] cpu_addr_hi,
	input wire logic [svrt_pkg::DATA_WIDTH-1:0] cpu_ad_in,
	output logic [svrt_pkg::DATA_WIDTH-1:0] cpu_ad_out,
	output logic cpu_ad_oe,
	input wire logic cpu_rw,
	input wire logic [svrt_pkg::SHARED_WIDTH-1:0] video_addr,
	input wire logic line_sync_raw_n,
	output logic e_clk,
	output logic address_strobe,
	output logic window,
	output logic line_sync_n,
	output logic video_sync_aligned,
	output logic [svrt_pkg::DATA_WIDTH-1:0] video_data,
	output logic ram_owner_select_n,
	output logic [svrt_pkg::SHARED_WIDTH-1:0] shared_addr,
	output logic shared_addr_bit11,
	output logic [svrt_pkg::CHIP_COUNT-1:0] ram_chip_sel_n,
	output logic [svrt_pkg::CHIP_COUNT-1:0] ram_oe_n,
	output logic ram_we_n,
	output logic io_sel_n,
	output logic rom_sel_n
);
	import svrt_pkg::*;

	typedef struct packed
	{
		logic [NCO_WIDTH-1:0] acc;
		logic [3:0] sub;
		logic [1:0] quarter;
		logic e;
		logic strobe;
		logic gate;
		logic [DATA_WIDTH-1:0] lo_addr;
		svrt_sync_type sync;
		logic aligned;
		logic fell_in_gate;
		logic [DATA_WIDTH-1:0] video;
		logic [DATA_WIDTH-1:0] cpu_rd;
	} svrt_state_type;

	svrt_state_type state_q;
	svrt_state_type state_d;

	logic [NCO_WIDTH:0] acc_sum;
	logic osc_tick;
	logic low_end;
	logic [ADDR_WIDTH-1:0] cpu_addr;
	logic cpu_owns;
	logic ram_hit;
	logic write_ok;
	logic [DATA_WIDTH-1:0] ram_rdata;

	// Segment of a processor address, taken from the two top bits.
	function automatic logic [1:0] seg_of(input logic [ADDR_WIDTH-1:0] a);
		seg_of = a[SEG_MSB:SEG_LSB]; // see RULE13
	endfunction

	// True when the address falls in the given segment.
	function automatic logic in_seg(input logic [ADDR_WIDTH-1:0] a,
		input logic [1:0] s);
		in_seg = (seg_of(a) == s);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Oscillator enable from a phase accumulator. The tick rate matches the
	// main clock on average; its spacing jitters by one system cycle.
	assign acc_sum = {1'b0, state_q.acc} + {1'b0, NCO_INC};
	assign osc_tick = acc_sum[NCO_WIDTH];
	assign low_end = osc_tick && (state_q.quarter == QTR_LOW_B);

	////////////////////////////////////////////////////////////////////////
	// Processor address and ownership decode.
	assign cpu_addr = {cpu_addr_hi, state_q.lo_addr};
	assign ram_hit = in_seg(cpu_addr, SEG_RAM);
	// The processor only owns the RAM during phase high. see RULE2
	assign cpu_owns = state_q.e && ram_hit;
	// Writes with address bit 12 set are dropped so the RAM does not alias whole.
	assign write_ok = !cpu_addr[ALIAS_BIT]; // see RULE14

	assign ram_owner_select_n = !cpu_owns; // see RULE8
	assign shared_addr = cpu_owns ? cpu_addr[SHARED_WIDTH-1:0] :
		video_addr; // see RULE8
	assign shared_addr_bit11 = shared_addr[CHIP_SEL_BIT];
	assign ram_chip_sel_n = shared_addr_bit11 ? 2'h1 : 2'h2; // see RULE9
	assign ram_oe_n = 2'h0; // see RULE10

	// Relies on the processor keeping address and data stable while
	// phase is high; the gate opens only after they have settled.
	assign ram_we_n = !(state_q.e && state_q.gate && ram_hit && write_ok &&
		!cpu_rw); // see RULE5 see RULE11 see RULE4

	assign io_sel_n = !(state_q.e && in_seg(cpu_addr, SEG_IO));
	assign rom_sel_n = !(state_q.e && in_seg(cpu_addr, SEG_ROM));

	assign cpu_ad_out = state_q.cpu_rd;
	assign cpu_ad_oe = state_q.e && cpu_rw && ram_hit;

	assign e_clk = state_q.e;
	assign address_strobe = state_q.strobe;
	assign window = state_q.gate;
	assign line_sync_n = (state_q.sync != SYNC_LOW);
	assign video_sync_aligned = state_q.aligned;
	assign video_data = state_q.video;

	////////////////////////////////////////////////////////////////////////
	svrt_ram #(
		.CHIPS(CHIP_COUNT),
		.CWIDTH(CHIP_WIDTH),
		.DWIDTH(DATA_WIDTH)
	)
	u_ram
	(
		.clock(clock),
		.resetn(resetn),
		.addr(shared_addr),
		.wdata(cpu_ad_in),
		.we_n(ram_we_n),
		.rdata(ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_d = state_q;
		state_d.acc = acc_sum[NCO_WIDTH-1:0];

		// Quarter counter: four oscillator ticks make one phase period.
		if (osc_tick)
		begin
			state_d.quarter = state_q.quarter + 2'h1; // see RULE1
			state_d.sub = 4'h0;
		end
		else if (state_q.sub != 4'hf)
		begin
			state_d.sub = state_q.sub + 4'h1;
		end
		state_d.e = state_d.quarter[1]; // see RULE1

		// Strobe is high in the first low quarter only.
		state_d.strobe = (state_d.quarter == QTR_LOW_A); // see RULE3
		if (state_q.strobe)
		begin
			state_d.lo_addr = cpu_ad_in; // see RULE3
		end

		// Gate opens a settle time into phase high and closes a guard time
		// ahead of the shortest possible phase fall.
		state_d.gate =
			((state_d.quarter == QTR_HIGH_A) &&
			(state_d.sub >= WIN_SETUP_CYC)) ||
			((state_d.quarter == QTR_HIGH_B) &&
			(state_d.sub < WIN_END_SUB)); // see RULE15

		if (state_q.e && cpu_rw && ram_hit)
		begin
			state_d.cpu_rd = ram_rdata;
		end

		// Sync fall is held off until the gate is open. see RULE6
		case (state_q.sync)
			SYNC_HIGH:
			begin
				if (!line_sync_raw_n)
				begin
					state_d.sync = state_q.gate ? SYNC_LOW : SYNC_HELD;
					// A later fall outside the gate must not hide an earlier
					// aligned one before the next capture reports it.
					state_d.fell_in_gate = state_q.fell_in_gate ||
						state_q.gate;
				end
			end
			SYNC_HELD:
			begin
				if (line_sync_raw_n)
				begin
					state_d.sync = SYNC_HIGH;
				end
				else if (state_q.gate)
				begin
					state_d.sync = SYNC_LOW;
					state_d.fell_in_gate = 1'b1;
				end
			end
			SYNC_LOW:
			begin
				if (line_sync_raw_n)
				begin
					state_d.sync = SYNC_HIGH;
				end
			end
			default:
			begin
				state_d.sync = SYNC_HIGH;
			end
		endcase

		// Video data is taken as the low half ends, while the video side
		// still owns the RAM, so neither party sees the other's cycle.
		if (low_end)
		begin
			state_d.video = ram_rdata; // see RULE7
			state_d.aligned = state_q.fell_in_gate; // see RULE7
			state_d.fell_in_gate = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q.acc <= NCO_RESET;
			state_q.sub <= 4'h0;
			state_q.quarter <= QTR_LOW_A;
			state_q.e <= 1'b0;
			state_q.strobe <= 1'b0;
			state_q.gate <= 1'b0;
			state_q.lo_addr <= 8'h00;
			state_q.sync <= SYNC_HIGH;
			state_q.aligned <= 1'b0;
			state_q.fell_in_gate <= 1'b0;
			state_q.video <= 8'h00;
			state_q.cpu_rd <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
		end
	end

endmodule

// *** verification/svrt_monitor.sv ***
// Timing checks on the ports of the shared video RAM timing block.
`timescale 1ns/10ps
module svrt_monitor
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] cpu_addr_hi,
	input wire logic cpu_rw,
	input wire logic [11:0] video_addr,
	input wire logic e_clk,
	input wire logic address_strobe,
	input wire logic window,
	input wire logic line_sync_n,
	input wire logic video_sync_aligned,
	input wire logic [7:0] video_data,
	input wire logic ram_owner_select_n,
	input wire logic [11:0] shared_addr,
	input wire logic shared_addr_bit11,
	input wire logic [1:0] ram_chip_sel_n,
	input wire logic [1:0] ram_oe_n,
	input wire logic ram_we_n,
	input wire logic io_sel_n,
	input wire logic rom_sel_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	// Each half of the phase clock is two quarters of 11 or 12 clocks.
	sequence s_high_half;
		##21 e_clk ##[1:3] !e_clk;
	endsequence
	sequence s_gate_inside;
		e_clk && $past(e_clk) ##1 e_clk;
	endsequence
	property p_divide;
		$rose(e_clk) |-> s_high_half;
	endproperty
	property p_video_owner;
		!e_clk |-> ram_owner_select_n;
	endproperty
	property p_strobe_low;
		address_strobe |-> !e_clk;
	endproperty
	property p_we_gated;
		!ram_we_n |-> window && e_clk && !cpu_rw;
	endproperty
	property p_we_alias;
		!ram_we_n |-> cpu_addr_hi[7:6] == 2'h1 && !cpu_addr_hi[4];
	endproperty
	property p_sync_fall;
		$fell(line_sync_n) |-> $past(window);
	endproperty
	property p_capture;
		($changed(video_data) || $changed(video_sync_aligned)) |-> $rose(e_clk);
	endproperty
	property p_addr_mux;
		ram_owner_select_n |-> shared_addr == video_addr;
	endproperty
	property p_chip_pick;
		shared_addr_bit11 == shared_addr[11]
			&& ram_chip_sel_n == {!shared_addr_bit11, shared_addr_bit11};
	endproperty
	property p_oe_tied;
		ram_oe_n == 2'h0;
	endproperty
	property p_decode;
		(!io_sel_n == (e_clk && cpu_addr_hi[7:6] == 2'h2))
			&& (!rom_sel_n == (e_clk && cpu_addr_hi[7:6] == 2'h3))
			&& (!ram_owner_select_n == (e_clk && cpu_addr_hi[7:6] == 2'h1));
	endproperty
	property p_gate;
		window |-> s_gate_inside;
	endproperty
	sequence s_low_half;
		##21 !e_clk ##[1:3] e_clk;
	endsequence
	property p_low_half;
		$fell(e_clk) |-> s_low_half;
	endproperty
	property p_strobe_start;
		$fell(e_clk) |-> address_strobe;
	endproperty
	property p_cpu_addr;
		!ram_owner_select_n |-> shared_addr[11:8] == cpu_addr_hi[3:0];
	endproperty
	a_divide: assert property (p_divide) else $error("phase length");
	a_video_owner: assert property (p_video_owner) else $error("owner");
	a_strobe_low: assert property (p_strobe_low) else $error("strobe");
	a_we_gated: assert property (p_we_gated) else $error("we gate");
	a_we_alias: assert property (p_we_alias) else $error("we alias");
	a_sync_fall: assert property (p_sync_fall) else $error("sync");
	a_capture: assert property (p_capture) else $error("capture");
	a_addr_mux: assert property (p_addr_mux) else $error("mux");
	a_chip_pick: assert property (p_chip_pick) else $error("chip");
	a_oe_tied: assert property (p_oe_tied) else $error("oe");
	a_decode: assert property (p_decode) else $error("decode");
	a_gate: assert property (p_gate) else $error("gate");
	a_low_half: assert property (p_low_half) else $error("low");
	a_strobe_start: assert property (p_strobe_start) else $error("latch");
	a_cpu_addr: assert property (p_cpu_addr) else $error("cpu addr");
endmodule

bind svrt_top svrt_monitor svrt_monitor_i (.clock, .resetn, .cpu_addr_hi,
	.cpu_rw, .video_addr, .e_clk, .address_strobe, .window, .line_sync_n,
	.video_sync_aligned, .video_data, .ram_owner_select_n, .shared_addr,
	.shared_addr_bit11, .ram_chip_sel_n, .ram_oe_n, .ram_we_n, .io_sel_n,
	.rom_sel_n);

// *** verification/svrt_cpu_model.sv ***
// Processor bus model: multiplexed address then data, held through phase high.
`timescale 1ns/10ps
module svrt_cpu_model
(
	input wire logic clock,
	input wire logic e_clk,
	input wire logic address_strobe,
	input wire logic [15:0] req_addr,
	input wire logic [7:0] req_data,
	input wire logic req_rw,
	output logic [7:0] cpu_addr_hi,
	output logic [7:0] cpu_ad_in,
	output logic cpu_rw
);
	logic e_prev = 1'b0;
	logic rw_q = 1'b1;
	logic [15:0] addr_q = 16'h0000;
	logic [7:0] data_q = 8'h00;
	logic [7:0] ad_q = 8'h00;
	assign cpu_addr_hi = addr_q[15:8];
	assign cpu_rw = rw_q;
	assign cpu_ad_in = ad_q;
	// A new request is taken only as the low half begins, so nothing moves
	// while the phase clock is high.
	always @(negedge clock)
	begin
		e_prev <= e_clk;
		if (e_prev && !e_clk)
		begin
			addr_q <= req_addr;
			data_q <= req_data;
			rw_q <= req_rw;
		end
		ad_q <= address_strobe ? addr_q[7:0] : data_q;
	end
endmodule

// *** verification/shared_video_ram_timing_tb_top.sv ***
// Self-checking bench: RAM traffic, video capture and line sync gating.
`timescale 1ns/10ps
module shared_video_ram_timing_tb_top;
	import svrt_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic line_sync_raw_n = 1'b1;
	logic req_rw = 1'b1;
	logic [15:0] req_addr = 16'h0000;
	logic [7:0] req_data = 8'h00;
	logic [11:0] video_addr = 12'h000;
	logic [11:0] last_wr = 12'h000;
	logic [7:0] cpu_addr_hi, cpu_ad_in, cpu_ad_out, video_data;
	logic cpu_rw, cpu_ad_oe, e_clk, address_strobe, window, line_sync_n;
	logic video_sync_aligned, ram_owner_select_n, shared_addr_bit11;
	logic ram_we_n, io_sel_n, rom_sel_n;
	logic [11:0] shared_addr;
	logic [1:0] ram_chip_sel_n, ram_oe_n;
	logic [7:0] mem [4096];
	logic [31:0] lf = 32'h00015da6;
	logic [24:0] dir [8] = '{{16'h4000, 8'ha5, 1'b0}, {16'h4800, 8'h3c, 1'b0},
		{16'h5000, 8'hff, 1'b0}, {16'h5000, 8'h00, 1'b1},
		{16'h4800, 8'h00, 1'b1}, {16'h8000, 8'h11, 1'b0},
		{16'hc000, 8'h22, 1'b0}, {16'h0000, 8'h33, 1'b0}};
	int err_count = 0;
	int compares = 0;
	initial forever #12.5 clock = !clock;
	svrt_top svrt_top_i (.clock, .resetn, .cpu_addr_hi, .cpu_ad_in,
		.cpu_ad_out, .cpu_ad_oe, .cpu_rw, .video_addr, .line_sync_raw_n, .e_clk,
		.address_strobe, .window, .line_sync_n, .video_sync_aligned,
		.video_data, .ram_owner_select_n, .shared_addr, .shared_addr_bit11,
		.ram_chip_sel_n, .ram_oe_n, .ram_we_n, .io_sel_n, .rom_sel_n);
	svrt_cpu_model svrt_cpu_model_i (.clock, .e_clk, .address_strobe,
		.req_addr, .req_data, .req_rw, .cpu_addr_hi, .cpu_ad_in, .cpu_rw);
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction
	function automatic logic hits_ram(input logic [15:0] a);
		return a[15:14] == SEG_RAM;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// The request is posted in a high half and runs in the next one.
	task automatic cpu_op(input logic [15:0] a, input logic [7:0] d,
		input logic rw);
		if (!e_clk)
			@(posedge e_clk);
		@(negedge clock);
		req_addr = a;
		req_data = d;
		req_rw = rw;
		// Often aim the video side at the last byte written, so that the
		// capture check compares against data that is not just zero.
		video_addr = lf[1] ? last_wr : lf[27:16];
		@(posedge e_clk);
		@(negedge clock);
		check(video_data, mem[video_addr]);
		repeat (14) @(negedge clock);
		check(cpu_ad_oe, hits_ram(a) && rw);
		if (hits_ram(a) && rw)
			check(cpu_ad_out, mem[a[11:0]]);
		if (hits_ram(a) && !rw && !a[12])
		begin
			mem[a[11:0]] = d;
			last_wr = a[11:0];
		end
	endtask
	task automatic sync_test;
		@(negedge e_clk);
		@(negedge clock);
		line_sync_raw_n = 1'b0;
		repeat (3) @(negedge clock);
		check(line_sync_n, 1'b1);
		@(posedge window);
		repeat (2) @(negedge clock);
		check(line_sync_n, 1'b0);
		@(posedge e_clk);
		@(negedge clock);
		check(video_sync_aligned, 1'b1);
		line_sync_raw_n = 1'b1;
		@(posedge e_clk);
		@(negedge clock);
		check(video_sync_aligned, 1'b0);
		check(line_sync_n, 1'b1);
		@(posedge window);
		@(negedge clock);
		line_sync_raw_n = 1'b0;
		@(negedge clock);
		check(line_sync_n, 1'b0);
		line_sync_raw_n = 1'b1;
		@(negedge e_clk);
		@(negedge clock);
		line_sync_raw_n = 1'b0;
		repeat (2) @(negedge clock);
		line_sync_raw_n = 1'b1;
		@(posedge e_clk);
		@(negedge clock);
		check(video_sync_aligned, 1'b1);
		@(posedge window);
		repeat (2) @(negedge clock);
		check(line_sync_n, 1'b1);
		@(posedge e_clk);
		@(negedge clock);
		check(video_sync_aligned, 1'b0);
	endtask
	////////////////////////////////////////
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h00;
		repeat (8) @(negedge clock);
		resetn = 1'b1;
		foreach (dir[i])
			cpu_op(dir[i][24:9], dir[i][8:1], dir[i][0]);
		repeat (70)
		begin
			lf = lfsr(lf);
			cpu_op(lf[2] ? {2'h1, lf[13:0]} : lf[15:0], lf[23:16], lf[3]);
		end
		sync_test();
		close_out();
	end
	initial
	begin
		repeat (40000) @(posedge clock);
		err_count++;
		close_out();
	end
endmodule
